// ==== hdl/fpx_pkg.sv ====
package fpx_pkg;

  // ---------------------------------------------
  // widths and encodings
  // ---------------------------------------------
  localparam int unsigned DATA_W = 80;
  localparam int unsigned SIG_W = 64;
  localparam int unsigned EXP_W = 18;
  localparam int unsigned EFLD_W = 15;
  localparam int unsigned FLAG_W = 6;
  localparam int unsigned INT_W = 7;
  localparam int unsigned ADDR_W = 12;

  typedef enum logic [1:0] {
    FPX_FMT_HALF = 2'b00,
    FPX_FMT_SINGLE = 2'b01,
    FPX_FMT_DOUBLE = 2'b10,
    FPX_FMT_EXT = 2'b11
  } fpx_fmt_t;

  typedef enum logic [1:0] {
    FPX_OP_ADD = 2'b00,
    FPX_OP_SUB = 2'b01,
    FPX_OP_MUL = 2'b10,
    FPX_OP_DIV = 2'b11
  } fpx_op_t;

  typedef enum logic [1:0] {
    FPX_RND_NEAREST = 2'b00,
    FPX_RND_DOWN = 2'b01,
    FPX_RND_UP = 2'b10,
    FPX_RND_ZERO = 2'b11
  } fpx_rnd_t;

  // ---------------------------------------------
  // register map and fields
  // ---------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CSR = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_INT_CLR = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_INT_EN = 12'h00c;

  localparam int unsigned FLG_INV = 0;
  localparam int unsigned FLG_DEN = 1;
  localparam int unsigned FLG_ZDIV = 2;
  localparam int unsigned FLG_OVF = 3;
  localparam int unsigned FLG_UNF = 4;
  localparam int unsigned FLG_INX = 5;
  localparam int unsigned INT_HREQ = 6;
  localparam int unsigned FLAG_LSB = 0;
  localparam int unsigned MASK_LSB = 7;
  localparam int unsigned RND_LSB = 13;

  localparam logic [FLAG_W-1:0] FLAG_RST = 6'h00;
  localparam logic [FLAG_W-1:0] MASK_RST = 6'h3f;
  localparam logic [1:0] RND_RST = 2'h0;

  // ---------------------------------------------
  // significand patterns for substitutes
  // ---------------------------------------------
  localparam logic [SIG_W-1:0] SIG_INF = 64'h8000_0000_0000_0000;
  localparam logic [SIG_W-1:0] SIG_QNAN = 64'hc000_0000_0000_0000;
  localparam logic [SIG_W-1:0] SIG_MAX = 64'hffff_ffff_ffff_ffff;
  localparam logic [EFLD_W-1:0] EFLD_MIN_NORM = 15'h0001;

  // ---------------------------------------------
  // per-format constants
  // ---------------------------------------------
  function automatic logic [EFLD_W-1:0] exp_ones(input fpx_fmt_t f);
    case (f)
      FPX_FMT_HALF: exp_ones = 15'h001f;
      FPX_FMT_SINGLE: exp_ones = 15'h00ff;
      FPX_FMT_DOUBLE: exp_ones = 15'h07ff;
      default: exp_ones = 15'h7fff;
    endcase
  endfunction

  function automatic logic signed [EXP_W-1:0] bias(input fpx_fmt_t f);
    case (f)
      FPX_FMT_HALF: bias = 18'sh0000f;
      FPX_FMT_SINGLE: bias = 18'sh0007f;
      FPX_FMT_DOUBLE: bias = 18'sh003ff;
      default: bias = 18'sh03fff;
    endcase
  endfunction

  // exponent bias shift for the stack unit's trapped results: 3 * 2^(ew-2)
  function automatic logic signed [EXP_W-1:0] wrap_adj(input fpx_fmt_t f);
    case (f)
      FPX_FMT_HALF: wrap_adj = 18'sh00018;
      FPX_FMT_SINGLE: wrap_adj = 18'sh000c0;
      FPX_FMT_DOUBLE: wrap_adj = 18'sh00600;
      default: wrap_adj = 18'sh06000;
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] sign_bit(input fpx_fmt_t f);
    case (f)
      FPX_FMT_HALF: sign_bit = 80'h0000_0000_0000_0000_8000;
      FPX_FMT_SINGLE: sign_bit = 80'h0000_0000_0000_8000_0000;
      FPX_FMT_DOUBLE: sign_bit = 80'h0000_8000_0000_0000_0000;
      default: sign_bit = 80'h8000_0000_0000_0000_0000;
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] min_norm(input fpx_fmt_t f);
    case (f)
      FPX_FMT_HALF: min_norm = 80'h0000_0000_0000_0000_0400;
      FPX_FMT_SINGLE: min_norm = 80'h0000_0000_0000_0080_0000;
      FPX_FMT_DOUBLE: min_norm = 80'h0000_0010_0000_0000_0000;
      default: min_norm = 80'h0001_8000_0000_0000_0000;
    endcase
  endfunction

endpackage

// ==== hdl/fpx_class_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface fpx_class_if;
  logic sign;
  logic zero;
  logic denorm;
  logic inf;
  logic nan;
  logic snan;
  modport src (output sign, zero, denorm, inf, nan, snan);
  modport dst (input sign, zero, denorm, inf, nan, snan);
endinterface
`default_nettype wire

// ==== hdl/fpx_class.sv ====
`timescale 1ns/100ps
`default_nettype none
module fpx_class (
  input wire fpx_pkg::fpx_fmt_t fmt,
  input wire logic [fpx_pkg::DATA_W-1:0] raw,
  fpx_class_if.src cls
);
  // ---------------------------------------------
  // field extraction, fraction left-aligned
  // ---------------------------------------------
  wire logic is_h = (fmt == fpx_pkg::FPX_FMT_HALF);
  wire logic is_s = (fmt == fpx_pkg::FPX_FMT_SINGLE);
  wire logic is_d = (fmt == fpx_pkg::FPX_FMT_DOUBLE);
  wire logic [fpx_pkg::EFLD_W-1:0] efld;
  wire logic [62:0] frac;
  wire logic all_ones;
  assign efld = is_h ? {10'h000, raw[14:10]} :
                is_s ? {7'h00, raw[30:23]} :
                is_d ? {4'h0, raw[62:52]} : raw[78:64];
  // extended integer bit is ignored here; unnormals classify by fraction
  assign frac = is_h ? {raw[9:0], 53'h0} :
                is_s ? {raw[22:0], 40'h0} :
                is_d ? {raw[51:0], 11'h0} : raw[62:0];
  assign cls.sign = is_h ? raw[15] : is_s ? raw[31] : is_d ? raw[63] : raw[79];
  assign all_ones = (efld == fpx_pkg::exp_ones(fmt));
  assign cls.zero = (efld == 15'h0000) && (frac == 63'h0);
  assign cls.denorm = (efld == 15'h0000) && (frac != 63'h0);
  assign cls.inf = all_ones && (frac == 63'h0);
  assign cls.nan = all_ones && (frac != 63'h0);
  assign cls.snan = cls.nan && !frac[62];
endmodule
`default_nettype wire

// ==== hdl/fpx_pack.sv ====
`timescale 1ns/100ps
`default_nettype none
module fpx_pack (
  input wire fpx_pkg::fpx_fmt_t fmt,
  input wire logic sign,
  input wire logic [fpx_pkg::EFLD_W-1:0] efld,
  input wire logic [fpx_pkg::SIG_W-1:0] sig,
  output logic [fpx_pkg::DATA_W-1:0] bits
);
  // ---------------------------------------------
  // packing, hidden bit dropped except extended
  // ---------------------------------------------
  always_comb
  begin
    case (fmt)
      fpx_pkg::FPX_FMT_HALF: bits = {64'h0, sign, efld[4:0], sig[62:53]};
      fpx_pkg::FPX_FMT_SINGLE: bits = {48'h0, sign, efld[7:0], sig[62:40]};
      fpx_pkg::FPX_FMT_DOUBLE: bits = {16'h0, sign, efld[10:0], sig[62:11]};
      default: bits = {sign, efld, sig};
    endcase
  end
endmodule
`default_nettype wire

// ==== hdl/fpx_exc_unit.sv ====
`timescale 1ns/100ps
`default_nettype none
module fpx_exc_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fpx_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_valid,
  output logic op_ready,
  input wire fpx_pkg::fpx_op_t op_kind,
  input wire fpx_pkg::fpx_fmt_t op_fmt,
  input wire logic op_stack,
  input wire logic [fpx_pkg::DATA_W-1:0] op_a,
  input wire logic [fpx_pkg::DATA_W-1:0] op_b,
  output logic pre_done,
  output logic pre_go,
  input wire logic res_valid,
  input wire logic res_sign,
  input wire logic res_zero,
  input wire logic res_inexact,
  input wire logic signed [fpx_pkg::EXP_W-1:0] res_exp,
  input wire logic [fpx_pkg::SIG_W-1:0] res_sig,
  input wire logic [fpx_pkg::DATA_W-1:0] res_bits,
  output logic post_done,
  output logic dest_we,
  output logic [fpx_pkg::DATA_W-1:0] dest_data,
  output logic handler_req,
  output logic [1:0] round_select,
  output logic irq
);

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  typedef enum logic [0:0] {
    FPX_ST_IDLE = 1'b0,
    FPX_ST_WAIT_RES = 1'b1
  } fpx_state_t;

  fpx_state_t state_q;
  fpx_state_t state_d;
  fpx_pkg::fpx_fmt_t fmt_q;
  logic stack_q;
  logic [fpx_pkg::FLAG_W-1:0] flags_q;
  logic [fpx_pkg::FLAG_W-1:0] flags_d;
  logic [fpx_pkg::FLAG_W-1:0] mask_q;
  logic [1:0] rnd_q;
  logic [fpx_pkg::INT_W-1:0] istat_q;
  logic [fpx_pkg::INT_W-1:0] istat_d;
  logic [fpx_pkg::INT_W-1:0] ien_q;
  logic irq_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic op_ready_q;
  logic pre_done_q;
  logic pre_go_q;
  logic post_done_q;
  logic dest_we_q;
  logic [fpx_pkg::DATA_W-1:0] dest_data_q;
  logic handler_req_q;

  // ---------------------------------------------
  // apb decode
  // ---------------------------------------------
  wire logic apb_setup = psel && !penable && !pready_q;
  wire logic apb_done = psel && penable && pready_q;
  wire logic hit_csr = (paddr == fpx_pkg::ADDR_CSR);
  wire logic hit_istat = (paddr == fpx_pkg::ADDR_INT_STAT);
  wire logic hit_iclr = (paddr == fpx_pkg::ADDR_INT_CLR);
  wire logic hit_ien = (paddr == fpx_pkg::ADDR_INT_EN);
  wire logic hit_any = hit_csr || hit_istat || hit_iclr || hit_ien;
  wire logic wr_csr = apb_done && pwrite && hit_csr;
  wire logic wr_iclr = apb_done && pwrite && hit_iclr;
  wire logic wr_ien = apb_done && pwrite && hit_ien;
  wire logic [31:0] csr_view;
  wire logic [31:0] rd_mux;
  assign csr_view = {17'h0, rnd_q, mask_q, 1'b0, flags_q};
  assign rd_mux = hit_csr ? csr_view :
                  hit_istat ? {25'h0, istat_q} :
                  hit_ien ? {25'h0, ien_q} : 32'h0000_0000;

  // ---------------------------------------------
  // operand classes and masks
  // ---------------------------------------------
  fpx_class_if ca ();
  fpx_class_if cb ();

  fpx_class u_class_a (
    .fmt(op_fmt),
    .raw(op_a),
    .cls(ca)
  );

  fpx_class u_class_b (
    .fmt(op_fmt),
    .raw(op_b),
    .cls(cb)
  );

  wire logic m_inv = mask_q[fpx_pkg::FLG_INV];
  wire logic m_den = mask_q[fpx_pkg::FLG_DEN];
  wire logic m_zdiv = mask_q[fpx_pkg::FLG_ZDIV];
  wire logic m_ovf = mask_q[fpx_pkg::FLG_OVF];
  wire logic m_unf = mask_q[fpx_pkg::FLG_UNF];
  wire logic m_inx = mask_q[fpx_pkg::FLG_INX];

  // ---------------------------------------------
  // pre-computation checks
  // ---------------------------------------------
  wire logic op_take = op_valid && op_ready_q;
  wire logic is_div = (op_kind == fpx_pkg::FPX_OP_DIV);
  wire logic is_mul = (op_kind == fpx_pkg::FPX_OP_MUL);
  wire logic is_sub = (op_kind == fpx_pkg::FPX_OP_SUB);
  wire logic any_nan = ca.nan || cb.nan;
  wire logic inv_div = is_div && ((ca.zero && cb.zero) || (ca.inf && cb.inf));
  wire logic inv_mul = is_mul && ((ca.zero && cb.inf) || (ca.inf && cb.zero));
  wire logic inv_add = !is_div && !is_mul && ca.inf && cb.inf
                       && (ca.sign ^ cb.sign ^ is_sub);
  wire logic pre_inv = ca.snan || cb.snan || inv_div || inv_mul || inv_add;
  // finite non-zero dividend only; nan or infinity never divides by zero
  wire logic dvd_ok = !ca.zero && !ca.inf && !ca.nan;
  wire logic pre_zdiv = is_div && dvd_ok && cb.zero && !pre_inv;
  // quiet nan handling outranks the denormal check
  wire logic pre_den = (ca.denorm || cb.denorm) && !pre_inv && !pre_zdiv && !any_nan;
  wire logic pre_trap = (pre_inv && !m_inv) || (pre_zdiv && !m_zdiv)
                        || (pre_den && !m_den);
  wire logic pre_wr = (pre_inv && m_inv) || (pre_zdiv && m_zdiv);
  // a masked denormal still lets the datapath carry on with the operand
  wire logic pre_cont = !pre_inv && !pre_zdiv && (!pre_den || m_den);

  // ---------------------------------------------
  // post-rounding checks
  // ---------------------------------------------
  wire logic res_take = res_valid && (state_q == FPX_ST_WAIT_RES);
  wire logic signed [fpx_pkg::EXP_W-1:0] ovf_lim;
  wire logic signed [fpx_pkg::EXP_W-1:0] tiny_lim;
  assign ovf_lim = fpx_pkg::bias(fmt_q) + 18'sh00001;
  assign tiny_lim = 18'sh00001 - fpx_pkg::bias(fmt_q);
  wire logic post_ovf = !res_zero && (res_exp >= ovf_lim);
  wire logic post_tiny = !res_zero && (res_exp < tiny_lim);
  // masked underflow needs inexactness too, unmasked flags any tiny value
  wire logic post_unf = post_tiny && (!m_unf || res_inexact);
  wire logic post_trap = (post_ovf && !m_ovf) || (post_tiny && !m_unf)
                         || (res_inexact && !m_inx);
  wire logic op_stack_sel = stack_q;
  wire logic post_biased = op_stack_sel && ((post_ovf && !m_ovf) || (post_tiny && !m_unf));
  // vector unit leaves its destination alone on an unmasked overflow or underflow; an inexact trap still writes
  wire logic post_hold = !stack_q && ((post_ovf && !m_ovf) || (post_tiny && !m_unf));

  // ---------------------------------------------
  // overflow substitute by rounding mode
  // ---------------------------------------------
  wire logic rnd_to_max;
  assign rnd_to_max = (rnd_q == fpx_pkg::FPX_RND_ZERO)
                   || ((rnd_q == fpx_pkg::FPX_RND_DOWN) && !res_sign)
                   || ((rnd_q == fpx_pkg::FPX_RND_UP) && res_sign);

  // ---------------------------------------------
  // substitute packing
  // ---------------------------------------------
  wire logic signed [fpx_pkg::EXP_W-1:0] exp_biased;
  wire logic pk_sign;
  wire logic [fpx_pkg::EFLD_W-1:0] pk_efld;
  wire logic [fpx_pkg::SIG_W-1:0] pk_sig;
  wire logic [fpx_pkg::DATA_W-1:0] pk_bits;
  wire logic [fpx_pkg::EFLD_W-1:0] ones_fld;
  assign ones_fld = fpx_pkg::exp_ones(op_take ? op_fmt : fmt_q);
  // overflow shifts the exponent down, underflow shifts it up
  assign exp_biased = post_ovf ? res_exp + fpx_pkg::bias(fmt_q) - fpx_pkg::wrap_adj(fmt_q)
                               : res_exp + fpx_pkg::bias(fmt_q) + fpx_pkg::wrap_adj(fmt_q);
  assign pk_sign = op_take ? (pre_inv || (ca.sign ^ cb.sign)) : res_sign;
  assign pk_efld = op_take ? ones_fld :
                   post_biased ? exp_biased[fpx_pkg::EFLD_W-1:0] :
                   rnd_to_max ? ones_fld - 15'h0001 : ones_fld;
  assign pk_sig = op_take ? (pre_inv ? fpx_pkg::SIG_QNAN : fpx_pkg::SIG_INF) :
                  post_biased ? res_sig :
                  rnd_to_max ? fpx_pkg::SIG_MAX : fpx_pkg::SIG_INF;

  fpx_pack u_pack (
    .fmt(op_take ? op_fmt : fmt_q),
    .sign(pk_sign),
    .efld(pk_efld),
    .sig(pk_sig),
    .bits(pk_bits)
  );

  // ---------------------------------------------
  // tiny result clamp, masked underflow
  // ---------------------------------------------
  wire logic [fpx_pkg::DATA_W-1:0] sbit;
  wire logic [fpx_pkg::DATA_W-1:0] mag;
  wire logic [fpx_pkg::DATA_W-1:0] mag_cl;
  wire logic [fpx_pkg::DATA_W-1:0] tiny_res;
  wire logic [fpx_pkg::DATA_W-1:0] post_res;
  assign sbit = fpx_pkg::sign_bit(fmt_q);
  assign mag = res_bits & ~sbit;
  // encodings are ordered by magnitude within a format, so a plain compare clamps
  assign mag_cl = (mag > fpx_pkg::min_norm(fmt_q)) ? fpx_pkg::min_norm(fmt_q) : mag;
  assign tiny_res = mag_cl | (res_sign ? sbit : 80'h0);
  assign post_res = (post_ovf && m_ovf) || post_biased ? pk_bits :
                    post_tiny ? tiny_res : res_bits;

  // ---------------------------------------------
  // condition events
  // ---------------------------------------------
  wire logic [fpx_pkg::FLAG_W-1:0] evt;
  assign evt[fpx_pkg::FLG_INV] = op_take && pre_inv;
  assign evt[fpx_pkg::FLG_DEN] = op_take && pre_den;
  assign evt[fpx_pkg::FLG_ZDIV] = op_take && pre_zdiv;
  assign evt[fpx_pkg::FLG_OVF] = res_take && post_ovf;
  assign evt[fpx_pkg::FLG_UNF] = res_take && post_unf;
  assign evt[fpx_pkg::FLG_INX] = res_take && res_inexact;
  wire logic hreq = (op_take && pre_trap) || (res_take && post_trap);

  // ---------------------------------------------
  // sticky flags and interrupt status
  // ---------------------------------------------
  // a software write replaces the flags, but a same-cycle event still lands
  assign flags_d = (wr_csr ? pwdata[fpx_pkg::FLAG_LSB +: fpx_pkg::FLAG_W] : flags_q)
                   | evt;
  assign istat_d = (istat_q & ~(wr_iclr ? pwdata[fpx_pkg::INT_W-1:0] : 7'h00))
                   | {hreq, evt};
  assign state_d = op_take && pre_cont ? FPX_ST_WAIT_RES :
                   res_take ? FPX_ST_IDLE : state_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_q <= fpx_pkg::FLAG_RST;
      mask_q <= fpx_pkg::MASK_RST;
      rnd_q <= fpx_pkg::RND_RST;
      istat_q <= 7'h00;
      ien_q <= 7'h00;
      irq_q <= 1'b0;
    end
    else
    begin
      flags_q <= flags_d;
      if (wr_csr)
      begin
        mask_q <= pwdata[fpx_pkg::MASK_LSB +: fpx_pkg::FLAG_W];
        rnd_q <= pwdata[fpx_pkg::RND_LSB +: 2];
      end
      istat_q <= istat_d;
      if (wr_ien)
        ien_q <= pwdata[fpx_pkg::INT_W-1:0];
      irq_q <= |(istat_d & (wr_ien ? pwdata[fpx_pkg::INT_W-1:0] : ien_q));
    end
  end

  // ---------------------------------------------
  // apb answer, no wait state
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup && !hit_any;
      prdata_q <= (apb_setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ---------------------------------------------
  // datapath handshake and destination
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= FPX_ST_IDLE;
      fmt_q <= fpx_pkg::FPX_FMT_HALF;
      stack_q <= 1'b0;
      op_ready_q <= 1'b0;
      pre_done_q <= 1'b0;
      pre_go_q <= 1'b0;
      post_done_q <= 1'b0;
      dest_we_q <= 1'b0;
      dest_data_q <= 80'h0;
      handler_req_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (op_take)
      begin
        fmt_q <= op_fmt;
        stack_q <= op_stack;
      end
      op_ready_q <= (state_d == FPX_ST_IDLE);
      pre_done_q <= op_take;
      pre_go_q <= op_take && pre_cont;
      post_done_q <= res_take;
      // unmasked pre checks never write; the result stays as it was
      dest_we_q <= (op_take && pre_wr)
                   || (res_take && !post_hold);
      if (op_take && pre_wr)
        dest_data_q <= pk_bits;
      else if (res_take && !post_hold)
        dest_data_q <= post_res;
      handler_req_q <= hreq;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign op_ready = op_ready_q;
  assign pre_done = pre_done_q;
  assign pre_go = pre_go_q;
  assign post_done = post_done_q;
  assign dest_we = dest_we_q;
  assign dest_data = dest_data_q;
  assign handler_req = handler_req_q;
  assign round_select = rnd_q;
  assign irq = irq_q;

endmodule
`default_nettype wire

// ==== testbench/fpx_exc_unit_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module fpx_exc_unit_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fpx_pkg::ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire logic pre_done,
  input wire logic pre_go,
  input wire logic res_valid,
  input wire logic post_done,
  input wire logic dest_we,
  input wire logic [fpx_pkg::DATA_W-1:0] dest_data,
  input wire logic handler_req,
  input wire logic [1:0] round_select
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ------------------------------
  // port relations
  // ------------------------------
  AST_APB_ANSWER:
    assert property (psel && !penable |=> pready) else $error("access not answered");
  AST_PRE_ANSWER:
    assert property (op_valid && op_ready |=> pre_done) else $error("no pre-check answer");
  // a trapped pre-check must leave the destination alone
  AST_PRE_TRAP:
    assert property (pre_done && handler_req && !post_done |-> !dest_we && !pre_go)
    else $error("trap with write or go");
  AST_GO_BUSY:
    assert property (pre_go |-> !op_ready) else $error("ready while computing");
  AST_POST_CAUSE:
    assert property (post_done |-> $past(res_valid) && !$past(op_ready))
    else $error("post check without result");
  AST_RND_HOLD:
    assert property ($changed(round_select) |-> $past(psel && penable && pwrite && paddr == 12'h000))
    else $error("round select moved alone");
  AST_DEST_HOLD:
    assert property ($changed(dest_data) |-> dest_we) else $error("destination changed unwritten");
  AST_HREQ_PHASE:
    assert property (handler_req |-> pre_done || post_done) else $error("stray handler request");
endmodule
bind fpx_exc_unit fpx_exc_unit_assertions chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pready, .op_valid, .op_ready, .pre_done, .pre_go, .res_valid, .post_done, .dest_we,
  .dest_data, .handler_req, .round_select);
`default_nettype wire

// ==== testbench/fpx_exc_unit_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module fpx_exc_unit_tb;
  localparam logic [79:0] ONE = 80'h3f80_0000;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic op_valid = 1'b0, op_stack = 1'b0, res_valid = 1'b0, res_sign = 1'b0;
  logic res_zero = 1'b0, res_inexact = 1'b0, sa, sb, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  fpx_pkg::fpx_op_t op_kind = fpx_pkg::FPX_OP_ADD;
  fpx_pkg::fpx_fmt_t op_fmt = fpx_pkg::FPX_FMT_SINGLE;
  logic [79:0] op_a = 80'h0, op_b = 80'h0, res_bits = 80'h4000_0000, dest_data, dd;
  logic signed [17:0] res_exp = 18'sh0;
  logic [63:0] res_sig = 64'h8000_0000_0000_0000;
  logic pready, pslverr, op_ready, pre_done, pre_go, post_done, dest_we, handler_req, irq;
  logic [1:0] round_select;
  logic [3:0] s;
  int n_mismatch = 0, n_checks = 0;
  fpx_exc_unit dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .op_valid, .op_ready, .op_kind, .op_fmt, .op_stack, .op_a, .op_b,
    .pre_done, .pre_go, .res_valid, .res_sign, .res_zero, .res_inexact, .res_exp, .res_sig,
    .res_bits, .post_done, .dest_we, .dest_data, .handler_req, .round_select, .irq);
  always #5 pclk = ~pclk;
  // ------------------------------
  // helpers
  // ------------------------------
  task automatic give_verdict;
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [83:0] got, input logic [83:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait, sampled mid-cycle so registered outputs have settled
  task automatic wt(ref logic x);
    repeat (20)
    begin
      @(negedge pclk);
      if (x === 1'b1)
        return;
    end
    n_mismatch++;
    $display("CHECK FAILED %0t wait ran out", $time);
    give_verdict;
  endtask
  // answer taken at the edge itself, since prdata stands only in the access cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
      begin
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        return;
      end
    end
    n_mismatch++;
    $display("CHECK FAILED %0t apb wait ran out", $time);
    give_verdict;
  endtask
  task automatic grab;
    @(negedge pclk);
    s = {pre_done | post_done, pre_go, dest_we, handler_req};
    dd = dest_data;
    @(posedge pclk);
  endtask
  task automatic op(input logic [1:0] k, input logic [79:0] a, input logic [79:0] b);
    op_valid <= 1'b1;
    op_kind <= fpx_pkg::fpx_op_t'(k);
    op_a <= a;
    op_b <= b;
    wt(op_ready);
    @(posedge pclk);
    op_valid <= 1'b0;
    grab;
  endtask
  task automatic res(input logic signed [17:0] e, input logic sg, input logic ix);
    res_valid <= 1'b1;
    res_exp <= e;
    res_sign <= sg;
    res_inexact <= ix;
    @(posedge pclk);
    res_valid <= 1'b0;
    grab;
  endtask
  task automatic ci(input logic e);
    @(negedge pclk);
    chk(84'(irq), 84'(e));
    @(posedge pclk);
  endtask
  // overflow substitute, single format
  function automatic logic [79:0] ovf(input logic [1:0] m, input logic sg);
    logic big;
    big = (m == 2'b00) || (m == 2'b01 && sg) || (m == 2'b10 && !sg);
    return {48'h0, sg, big ? 31'h7f80_0000 : 31'h7f7f_ffff};
  endfunction
  initial
  begin
    void'($urandom(32'hc6b65cfe));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk(84'(rd), 84'h1f80);
    apb(1'b0, 12'h010, 32'h0);
    chk(84'({er, rd}), 84'h1_0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      sa = 1'($urandom);
      sb = 1'($urandom);
      op(2'b11, {48'h0, sa, 8'h7f, 23'($urandom)}, {48'h0, sb, 31'h0});
      chk({s, dd}, {4'b1010, 48'h0, sa ^ sb, 31'h7f80_0000});
    end
    op(2'b11, 80'h0, 80'h0);
    chk({s, dd}, {4'b1010, 80'hffc0_0000});
    op(2'b00, 80'h1, ONE);
    chk(84'(s), 84'hc);
    res(18'sd0, 1'b0, 1'b0);
    chk({s, dd}, {4'b1010, res_bits});
    apb(1'b0, 12'h000, 32'h0);
    chk(84'(rd), 84'h1f87);
    // masked tiny and inexact: clamped to the negative smallest normal
    op(2'b00, ONE, ONE);
    res(-18'sd127, 1'b1, 1'b1);
    chk({s, dd}, {4'b1010, 80'h8080_0000});
    for (int m = 0; m < 8; m++)
    begin
      apb(1'b1, 12'h000, {17'h0, 2'(m >> 1), 13'h1f80});
      op(2'b00, ONE, ONE);
      res(18'sd128, 1'(m), 1'b1);
      chk({s, dd}, {4'b1010, ovf(2'(m >> 1), 1'(m))});
    end
    chk(84'(round_select), 84'h3);
    apb(1'b1, 12'h000, 32'h1580);
    op(2'b11, ONE, 80'h0);
    chk({s, dd}, {4'b1001, ovf(2'h3, 1'b1)});
    op(2'b00, ONE, ONE);
    res(-18'sd127, 1'b0, 1'b0);
    chk({s, dd}, {4'b1001, ovf(2'h3, 1'b1)});
    // stack unit keeps the trapped tiny result, exponent field moved up by 192
    op_stack <= 1'b1;
    op(2'b00, ONE, ONE);
    res(-18'sd127, 1'b0, 1'b0);
    chk({s, dd}, {4'b1011, 80'h6000_0000});
    apb(1'b0, 12'h000, 32'h0);
    // the csr write replaced the flags, so only zero-divide and underflow remain
    chk(84'(rd), 84'h1594);
    apb(1'b1, 12'h00c, 32'h4);
    ci(1'b1);
    apb(1'b1, 12'h00c, 32'h0);
    ci(1'b0);
    apb(1'b1, 12'h00c, 32'h4);
    apb(1'b1, 12'h008, 32'h7f);
    ci(1'b0);
    give_verdict;
  end
endmodule
`default_nettype wire
